// ---- verilog/prt_pkg.sv ----
package prt_pkg;

	// ==================================================================
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MRT  = 8'h04;
	localparam logic [7:0] ADDR_NRT  = 8'h08;
	localparam logic [7:0] ADDR_PPW  = 8'h0c;
	localparam logic [7:0] ADDR_GPT  = 8'h10;
	localparam logic [7:0] ADDR_WUT  = 8'h14;
	localparam logic [7:0] ADDR_CMD  = 8'h18;
	localparam logic [7:0] ADDR_STAT = 8'h1c;

	// ==================================================================
	// Control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MRT_STEP = 4;
	localparam int CTRL_NRT_STEP = 5;
	localparam int CTRL_NRT_UNC  = 6;
	localparam int CTRL_NRT_PEER = 7;
	localparam int CTRL_SQ_EN    = 8;
	localparam int CTRL_GPT_LSB  = 9;
	localparam int CTRL_W        = 11;
	localparam logic [10:0] CTRL_RESET = 11'h000;

	// ==================================================================
	// Command bits, each a one-shot on write
	localparam int CMD_STOP_ALL  = 0;
	localparam int CMD_START_MRT = 1;
	localparam int CMD_START_NRT = 2;
	localparam int CMD_STOP_NRT  = 3;
	localparam int CMD_START_GPT = 4;
	localparam int CMD_START_WUT = 5;
	localparam int CMD_W         = 6;

	// ==================================================================
	// Status fields: flags write-one-to-clear, busy bits read only
	localparam int ST_NRT_FLAG = 0;
	localparam int ST_PPW_FLAG = 1;
	localparam int ST_GPT_FLAG = 2;
	localparam int ST_WUT_FLAG = 3;
	localparam int ST_BUSY_LSB = 8;

	// ==================================================================
	// Step sizes as prescaler bit counts
	localparam int STEP64_BITS   = 6;
	localparam int STEP512_BITS  = 9;
	localparam int STEP4096_BITS = 12;

	// ==================================================================
	// Operating modes
	typedef enum logic [2:0] {
		MODE_READER  = 3'b000,
		MODE_ACT_INI = 3'b001,
		MODE_ACT_TGT = 3'b010,
		MODE_PAS_TGT = 3'b011,
		MODE_BITRATE = 3'b100,
		MODE_LP_TGT  = 3'b101,
		MODE_WAKEUP  = 3'b110
	} prt_mode_t;

	// General timer triggers
	typedef enum logic [1:0] {
		GPT_NONE     = 2'b00,
		GPT_RX_START = 2'b01,
		GPT_RX_END   = 2'b10,
		GPT_FIELD    = 2'b11
	} prt_gpt_trig_t;

endpackage : prt_pkg

// ---- verilog/prt_tmr_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// Carrier between the control block and one countdown timer
interface prt_tmr_if #(parameter int W = 16);
	logic         start;
	logic         stop;
	logic         tick;
	logic [W-1:0] load;
	logic         busy;
	logic         done;
	modport ctl (output start, output stop, output tick, output load,
		input busy, input done);
	modport tmr (input start, input stop, input tick, input load,
		output busy, output done);
endinterface : prt_tmr_if
`default_nettype wire

// ---- verilog/prt_tmr.sv ----
`timescale 1ns/100ps
`default_nettype none
module prt_tmr #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Timer carrier
	prt_tmr_if.tmr    t
);

	// ==================================================================
	// Elaboration check
	if (W < 2 || W > 16) begin : g_bad_w
		$error("prt_tmr width out of range");
	end

	logic [W-1:0] cnt_q;
	logic         busy_q;
	logic         done_q;

	// Countdown; stop beats start so a halt is never undone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (t.stop) begin
				busy_q <= 1'b0;
			end else if (t.start) begin
				cnt_q  <= t.load;
				busy_q <= 1'b1;
			end else if (busy_q && t.tick) begin
				if (cnt_q <= W'(1)) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q - W'(1);
				end
			end
		end
	end

	assign t.busy = busy_q;
	assign t.done = done_q;

endmodule : prt_tmr
`default_nettype wire

// ---- verilog/prt_top.sv ----
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module prt_top #(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Clocks and oscillator state
	input  wire logic        fc_tick,
	input  wire logic        rc_tick,
	input  wire logic        osc_ok,
	// Frame and field events, one-cycle pulses, and the reply-busy level
	input  wire logic        tx_end,
	input  wire logic        tx_field_off,
	input  wire logic        peer_field_on,
	input  wire logic        rx_sof,
	input  wire logic        rx_eof,
	input  wire logic        reply_busy,
	// Front end controls
	output logic             rx_enable,
	output logic             squelch_on,
	output logic             rc_osc_on,
	output logic             watch_rx,
	// Sticky expiry flags
	output logic             nrt_expired_flag,
	output logic             peer_field_wait_expired_flag,
	output logic             general_purpose_timer_flag,
	output logic             wakeup_timer_expired_flag
);

	// ==================================================================
	// Elaboration check
	if (CNT_W < 8 || CNT_W > 16) begin : g_bad_w
		$error("prt_top counter width out of range");
	end

	// True when the low n bits of the prescaler are all ones
	function automatic logic step_hit(input logic [11:0] p, input int n);
		logic [11:0] m;
		m = 12'((1 << n) - 1);
		return (p & m) == m;
	endfunction

	// ==================================================================
	// Registers and carriers
	logic [prt_pkg::CTRL_W-1:0] ctrl_q;
	logic [CNT_W-1:0]           mrt_cfg_q;
	logic [CNT_W-1:0]           nrt_cfg_q;
	logic [CNT_W-1:0]           ppw_cfg_q;
	logic [CNT_W-1:0]           gpt_cfg_q;
	logic [CNT_W-1:0]           wut_cfg_q;
	logic [prt_pkg::CMD_W-1:0]  cmd;
	logic [3:0]                 flag_q;
	logic [11:0]                pre_q;
	logic                       wr_en;
	logic                       setup;
	logic                       hit;

	prt_tmr_if #(.W(CNT_W)) mrt_if ();
	prt_tmr_if #(.W(CNT_W)) nrt_if ();
	prt_tmr_if #(.W(CNT_W)) ppw_if ();
	prt_tmr_if #(.W(CNT_W)) gpt_if ();
	prt_tmr_if #(.W(CNT_W)) wut_if ();

	prt_tmr #(.W(CNT_W)) u_mrt (.pclk(pclk), .presetn(presetn), .t(mrt_if));
	prt_tmr #(.W(CNT_W)) u_nrt (.pclk(pclk), .presetn(presetn), .t(nrt_if));
	prt_tmr #(.W(CNT_W)) u_ppw (.pclk(pclk), .presetn(presetn), .t(ppw_if));
	prt_tmr #(.W(CNT_W)) u_gpt (.pclk(pclk), .presetn(presetn), .t(gpt_if));
	prt_tmr #(.W(CNT_W)) u_wut (.pclk(pclk), .presetn(presetn), .t(wut_if));

	// ==================================================================
	// Decoded control fields
	prt_pkg::prt_mode_t     mode;
	prt_pkg::prt_gpt_trig_t gtrig;
	logic mrt_step;
	logic nrt_step;
	logic nrt_unc;
	logic nrt_peer;
	logic sq_en;
	logic p2p;
	logic active;

	assign mode     = prt_pkg::prt_mode_t'(ctrl_q[prt_pkg::CTRL_MODE_LSB +: 3]);
	assign gtrig    = prt_pkg::prt_gpt_trig_t'(ctrl_q[prt_pkg::CTRL_GPT_LSB +: 2]);
	assign mrt_step = ctrl_q[prt_pkg::CTRL_MRT_STEP];
	assign nrt_step = ctrl_q[prt_pkg::CTRL_NRT_STEP];
	assign nrt_unc  = ctrl_q[prt_pkg::CTRL_NRT_UNC];
	assign nrt_peer = ctrl_q[prt_pkg::CTRL_NRT_PEER];
	assign sq_en    = ctrl_q[prt_pkg::CTRL_SQ_EN];
	assign active   = (mode == prt_pkg::MODE_ACT_INI) || (mode == prt_pkg::MODE_ACT_TGT);
	assign p2p      = active || (mode == prt_pkg::MODE_PAS_TGT)
		|| (mode == prt_pkg::MODE_BITRATE) || (mode == prt_pkg::MODE_LP_TGT);

	// ==================================================================
	// APB slave: zero wait state, answer one cycle after setup
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && pready;
	assign hit   = (paddr == prt_pkg::ADDR_CTRL) || (paddr == prt_pkg::ADDR_MRT)
		|| (paddr == prt_pkg::ADDR_NRT) || (paddr == prt_pkg::ADDR_PPW)
		|| (paddr == prt_pkg::ADDR_GPT) || (paddr == prt_pkg::ADDR_WUT)
		|| (paddr == prt_pkg::ADDR_CMD) || (paddr == prt_pkg::ADDR_STAT);

	// Ready and error come up in the access phase only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup && !hit;
		end
	end

	// Read data captured at setup; command reads as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			if (paddr == prt_pkg::ADDR_CTRL) begin
				prdata <= 32'(ctrl_q);
			end else if (paddr == prt_pkg::ADDR_MRT) begin
				prdata <= 32'(mrt_cfg_q);
			end else if (paddr == prt_pkg::ADDR_NRT) begin
				prdata <= 32'(nrt_cfg_q);
			end else if (paddr == prt_pkg::ADDR_PPW) begin
				prdata <= 32'(ppw_cfg_q);
			end else if (paddr == prt_pkg::ADDR_GPT) begin
				prdata <= 32'(gpt_cfg_q);
			end else if (paddr == prt_pkg::ADDR_WUT) begin
				prdata <= 32'(wut_cfg_q);
			end else if (paddr == prt_pkg::ADDR_STAT) begin
				prdata <= 32'({wut_if.busy, gpt_if.busy, ppw_if.busy,
					nrt_if.busy, mrt_if.busy, 4'h0, flag_q});
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// Settings; not guarded while a timer runs, the host keeps off them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q    <= prt_pkg::CTRL_RESET;
			mrt_cfg_q <= '0;
			nrt_cfg_q <= '0;
			ppw_cfg_q <= '0;
			gpt_cfg_q <= '0;
			wut_cfg_q <= '0;
		end else if (wr_en) begin
			if (paddr == prt_pkg::ADDR_CTRL) begin
				ctrl_q <= pwdata[prt_pkg::CTRL_W-1:0];
			end else if (paddr == prt_pkg::ADDR_MRT) begin
				mrt_cfg_q <= pwdata[CNT_W-1:0];
			end else if (paddr == prt_pkg::ADDR_NRT) begin
				nrt_cfg_q <= pwdata[CNT_W-1:0];
			end else if (paddr == prt_pkg::ADDR_PPW) begin
				ppw_cfg_q <= pwdata[CNT_W-1:0];
			end else if (paddr == prt_pkg::ADDR_GPT) begin
				gpt_cfg_q <= pwdata[CNT_W-1:0];
			end else if (paddr == prt_pkg::ADDR_WUT) begin
				wut_cfg_q <= pwdata[CNT_W-1:0];
			end
		end
	end

	// Direct commands act in the write cycle itself
	assign cmd = (wr_en && paddr == prt_pkg::ADDR_CMD)
		? pwdata[prt_pkg::CMD_W-1:0] : '0;

	// ==================================================================
	// Carrier prescaler, frozen while the crystal is down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 12'h000;
		end else if (fc_tick && osc_ok) begin
			pre_q <= pre_q + 12'h001;
		end
	end

	logic t64;
	logic t512;
	logic t4096;
	logic lp_rc;
	assign t64   = fc_tick && osc_ok && step_hit(pre_q, prt_pkg::STEP64_BITS);
	assign t512  = fc_tick && osc_ok && step_hit(pre_q, prt_pkg::STEP512_BITS);
	assign t4096 = fc_tick && osc_ok && step_hit(pre_q, prt_pkg::STEP4096_BITS);
	// RC fallback keeps the mask time close before the crystal settles
	assign lp_rc = (mode == prt_pkg::MODE_LP_TGT) && !osc_ok;

	// ==================================================================
	// Mask receive timer
	assign mrt_if.load  = mrt_cfg_q;
	assign mrt_if.tick  = lp_rc ? rc_tick : (mrt_step ? t512 : t64);
	assign mrt_if.stop  = cmd[prt_pkg::CMD_STOP_ALL];
	assign mrt_if.start = tx_end
		|| cmd[prt_pkg::CMD_START_MRT]
		|| (peer_field_on && (active || mode == prt_pkg::MODE_PAS_TGT));

	// ==================================================================
	// No-response timer
	logic nrt_auto;
	assign nrt_auto = (tx_end && mode != prt_pkg::MODE_PAS_TGT)
		|| (active && nrt_peer && peer_field_on)
		|| ((active || mode == prt_pkg::MODE_BITRATE) && !nrt_peer
			&& gtrig == prt_pkg::GPT_FIELD && gpt_if.done);
	assign nrt_if.load  = nrt_cfg_q;
	assign nrt_if.tick  = nrt_step ? t4096 : t64;
	assign nrt_if.start = nrt_auto || cmd[prt_pkg::CMD_START_NRT];
	assign nrt_if.stop  = cmd[prt_pkg::CMD_STOP_NRT]
		|| (cmd[prt_pkg::CMD_STOP_ALL] && !nrt_unc)
		|| (rx_sof && !nrt_unc && nrt_if.busy && !nrt_if.start);

	// ==================================================================
	// Peer field wait timer, idle in reader mode
	assign ppw_if.load  = ppw_cfg_q;
	assign ppw_if.tick  = t64;
	assign ppw_if.start = tx_field_off && p2p;
	assign ppw_if.stop  = cmd[prt_pkg::CMD_STOP_ALL] || peer_field_on;

	// ==================================================================
	// General purpose timer
	assign gpt_if.load  = gpt_cfg_q;
	assign gpt_if.tick  = t64;
	assign gpt_if.stop  = cmd[prt_pkg::CMD_STOP_ALL];
	assign gpt_if.start = cmd[prt_pkg::CMD_START_GPT]
		|| (gtrig == prt_pkg::GPT_RX_START && rx_sof)
		|| (gtrig == prt_pkg::GPT_RX_END && rx_eof)
		|| (gtrig == prt_pkg::GPT_FIELD && active && tx_field_off);

	// ==================================================================
	// Wake-up timer on the RC clock only
	logic wut_go;
	assign wut_go       = cmd[prt_pkg::CMD_START_WUT] && mode != prt_pkg::MODE_WAKEUP;
	assign wut_if.load  = wut_cfg_q;
	assign wut_if.tick  = rc_tick;
	assign wut_if.start = wut_go;
	assign wut_if.stop  = cmd[prt_pkg::CMD_STOP_ALL];

	// RC oscillator runs while the wake-up timer or low-power mask needs it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_osc_on <= 1'b0;
		end else if (wut_go || (lp_rc && (mrt_if.start || mrt_if.busy))) begin
			rc_osc_on <= 1'b1;
		end else if (!wut_if.busy && !(lp_rc && mrt_if.busy)) begin
			rc_osc_on <= 1'b0;
		end
	end

	// ==================================================================
	// Sticky flags; a new expiry beats a clear in the same cycle
	logic [3:0] flag_set;
	logic [3:0] flag_clr;
	assign flag_set = {wut_if.done, gpt_if.done, ppw_if.done, nrt_if.done};
	assign flag_clr = (wr_en && paddr == prt_pkg::ADDR_STAT) ? pwdata[3:0] : 4'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 4'h0;
		end else begin
			flag_q <= (flag_q & ~flag_clr) | flag_set;
		end
	end

	// Flag outputs mirror the sticky flags one cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nrt_expired_flag             <= 1'b0;
			peer_field_wait_expired_flag <= 1'b0;
			general_purpose_timer_flag   <= 1'b0;
			wakeup_timer_expired_flag    <= 1'b0;
		end else begin
			nrt_expired_flag             <= flag_q[prt_pkg::ST_NRT_FLAG];
			peer_field_wait_expired_flag <= flag_q[prt_pkg::ST_PPW_FLAG];
			general_purpose_timer_flag   <= flag_q[prt_pkg::ST_GPT_FLAG];
			wakeup_timer_expired_flag    <= flag_q[prt_pkg::ST_WUT_FLAG];
		end
	end

	// ==================================================================
	// Receiver gate: closed while masked, opened at mask expiry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_enable <= 1'b0;
		end else if (mrt_if.start || mrt_if.busy) begin
			rx_enable <= 1'b0;
		end else if (nrt_if.done && !(nrt_unc && reply_busy)) begin
			rx_enable <= 1'b0;
		end else if (mrt_if.done) begin
			rx_enable <= 1'b1;
		end
	end

	// Squelch follows the mask timer when enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			squelch_on <= 1'b0;
		end else begin
			squelch_on <= sq_en && mrt_if.busy;
		end
	end

	// Low-power target: start-of-message watch opens after mask expiry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watch_rx <= 1'b0;
		end else if (mode != prt_pkg::MODE_LP_TGT || mrt_if.start) begin
			watch_rx <= 1'b0;
		end else if (mrt_if.done) begin
			watch_rx <= 1'b1;
		end
	end

	// ==================================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence tx_done_s;
		tx_end && !cmd[prt_pkg::CMD_STOP_ALL];
	endsequence

	mask_gate_a: assert property (mrt_if.busy |=> !rx_enable)
		else $error("receiver open while masked");
	mask_start_a: assert property (tx_done_s |=> mrt_if.busy)
		else $error("mask timer did not start at transmit end");
	nrt_auto_a: assert property (tx_done_s and (mode != prt_pkg::MODE_PAS_TGT
		&& !cmd[prt_pkg::CMD_STOP_NRT]) |=> nrt_if.busy)
		else $error("no-response timer did not start");
	nrt_pas_a: assert property (mode == prt_pkg::MODE_PAS_TGT && !nrt_if.busy
		&& !cmd[prt_pkg::CMD_START_NRT] |=> !nrt_if.busy)
		else $error("no-response started in passive target");
	stop_all_a: assert property (cmd[prt_pkg::CMD_STOP_ALL] && !nrt_unc
		|=> !nrt_if.busy && !gpt_if.busy && !ppw_if.busy)
		else $error("stop-all left a timer running");
	unc_keep_a: assert property (cmd[prt_pkg::CMD_STOP_ALL] && nrt_unc
		&& nrt_if.busy && !nrt_if.tick |=> nrt_if.busy)
		else $error("unconditional timer halted by stop-all");
	nrt_flag_a: assert property (nrt_if.done |=> flag_q[prt_pkg::ST_NRT_FLAG]
		##1 nrt_expired_flag)
		else $error("no-response expiry not flagged");
	nrt_drop_a: assert property (nrt_if.done && !nrt_unc && !mrt_if.start
		|=> !rx_enable)
		else $error("receiver not dropped at expiry");
	ppw_stop_a: assert property (peer_field_on |=> !ppw_if.busy)
		else $error("peer wait timer not stopped");
	wut_mode_a: assert property (cmd[prt_pkg::CMD_START_WUT]
		&& mode == prt_pkg::MODE_WAKEUP && !wut_if.busy |=> !wut_if.busy)
		else $error("wake-up start taken in wake mode");
	osc_hold_a: assert property (!osc_ok |=> $stable(pre_q))
		else $error("carrier prescaler moved without crystal");

endmodule : prt_top
`default_nettype wire

// ---- verification/prt_fe_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==============================
// Front end clock sources
module prt_fe_model (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// RC oscillator request
	input  wire logic rc_osc_on,
	// Tick pulses
	output logic      fc_tick,
	output logic      rc_tick
);
	logic [3:0] div_q;

	// Free divider, carrier every 2nd cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 4'h0;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end
	assign fc_tick = div_q[0];
	// RC stands still unless requested
	assign rc_tick = rc_osc_on && (div_q == 4'hf);
endmodule // prt_fe_model
`default_nettype wire

// ---- verification/test_rf_frontend_protocol_timers.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module test_rf_frontend_protocol_timers;
	// ==============================
	// Signals
	logic        pclk, presetn, psel, penable, pwrite, osc_ok, reply_busy;
	logic        pready, pslverr, fc_tick, rc_tick, rx_enable, squelch_on;
	logic        rc_osc_on, watch_rx;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, sv;
	logic [4:0]  evt;
	logic [3:0]  fl;
	logic [33:0] expq[$];
	logic [33:0] e;
	int          errors, comparisons;

	prt_top prt_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fc_tick(fc_tick), .rc_tick(rc_tick), .osc_ok(osc_ok),
		.tx_end(evt[0]), .tx_field_off(evt[1]), .peer_field_on(evt[2]), .rx_sof(evt[3]),
		.rx_eof(evt[4]), .reply_busy(reply_busy), .rx_enable(rx_enable),
		.squelch_on(squelch_on), .rc_osc_on(rc_osc_on), .watch_rx(watch_rx),
		.nrt_expired_flag(fl[0]), .peer_field_wait_expired_flag(fl[1]),
		.general_purpose_timer_flag(fl[2]), .wakeup_timer_expired_flag(fl[3]));
	prt_fe_model prt_fe_model_inst (.pclk(pclk), .presetn(presetn), .rc_osc_on(rc_osc_on),
		.fc_tick(fc_tick), .rc_tick(rc_tick));

	// 200 MHz clock
	always #2.5 pclk = ~pclk;

	// Read monitor, oldest note first
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			e = expq.pop_front();
			if (e[33]) `CHK("prdata", e[32:0], {pslverr, prdata})
		end
	end

	// ==============================
	// Bus and event tasks
	task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [33:0] x);
		int n;
		n = 0;
		if (!w) expq.push_back(x);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20) errors++;
		sv = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xf(a, 1'b1, d, 34'h0);
	endtask
	task st(input logic [32:0] x);
		xf(prt_pkg::ADDR_STAT, 1'b0, 32'h0, {1'b1, x});
	endtask
	task ctl(input logic [31:0] d);
		wr(prt_pkg::ADDR_CTRL, d);
	endtask
	task cmd(input logic [31:0] d);
		wr(prt_pkg::ADDR_CMD, d);
	endtask
	task clr;
		wr(prt_pkg::ADDR_STAT, 32'hf);
	endtask
	task ev(input int i);
		evt[i] <= 1'b1;
		@(posedge pclk);
		evt <= 5'h0;
		@(posedge pclk);
	endtask
	// Poll until every timer is idle
	task automatic idle;
		int n;
		n = 0;
		do xf(prt_pkg::ADDR_STAT, 1'b0, 32'h0, 34'h0); while (sv[12:8] != 5'h0 && ++n < 6000);
		if (n >= 6000) errors++;
	endtask
	task tally_and_finish;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Watchdog, well beyond the expected run
	initial begin
		#400000;
		errors++;
		tally_and_finish;
	end

	// ==============================
	// Main sequence; settings only written while timers idle
	initial begin
		int n;
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		osc_ok = 1'b1;
		reply_busy = 1'b0;
		evt = 5'h0;
		errors = 0;
		comparisons = 0;
		void'($urandom(32'hff5efb47));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xf(prt_pkg::ADDR_CTRL, 1'b0, 32'h0, 34'h2_0000_0000);
		st(33'h0);
		xf(8'h20, 1'b0, 32'h0, 34'h3_0000_0000);
		// Expiry after transmit, then silent stop on reply
		wr(prt_pkg::ADDR_NRT, 32'h2);
		ev(0);
		idle;
		st(33'h1);
		`CHK("rx_enable", 1'b0, rx_enable)
		`CHK("nrt_flag", 1'b1, fl[0])
		clr;
		ev(0);
		ev(3);
		idle;
		st(33'h0);
		`CHK("rx_enable", 1'b1, rx_enable)
		// Mask gate and squelch after transmit
		ctl(32'h100);
		wr(prt_pkg::ADDR_MRT, 32'h3);
		wr(prt_pkg::ADDR_NRT, 32'h40);
		ev(0);
		repeat (2) @(posedge pclk);
		`CHK("rx_enable", 1'b0, rx_enable)
		`CHK("squelch_on", 1'b1, squelch_on)
		n = 0;
		while (rx_enable !== 1'b1 && ++n < 2000) @(posedge pclk);
		if (n >= 2000) errors++;
		st(33'h200);
		`CHK("squelch_on", 1'b0, squelch_on)
		cmd(32'h1);
		cmd(32'h2);
		repeat (2) @(posedge pclk);
		`CHK("squelch_on", 1'b1, squelch_on)
		st(33'h100);
		idle;
		// Coarse steps still busy where fine ones would be done
		ctl(32'h30);
		wr(prt_pkg::ADDR_MRT, 32'h2);
		wr(prt_pkg::ADDR_NRT, 32'h2);
		cmd(32'h6);
		repeat (500) @(posedge pclk);
		st(33'h300);
		cmd(32'h1);
		st(33'h0);
		// Unconditional mode survives stop-all
		ctl(32'h40);
		wr(prt_pkg::ADDR_NRT, 32'h3);
		cmd(32'h4);
		cmd(32'h4);
		cmd(32'h1);
		st(33'h200);
		idle;
		st(33'h1);
		clr;
		// Reply in progress keeps the receiver open at expiry
		reply_busy <= 1'b1;
		cmd(32'h6);
		ev(3);
		idle;
		`CHK("rx_enable", 1'b1, rx_enable)
		st(33'h1);
		reply_busy <= 1'b0;
		clr;
		cmd(32'h4);
		cmd(32'h8);
		st(33'h0);
		// Peer wait timer in passive target
		ctl(32'h3);
		wr(prt_pkg::ADDR_PPW, 32'h2);
		ev(1);
		idle;
		st(33'h2);
		`CHK("ppw_flag", 1'b1, fl[1])
		clr;
		ev(1);
		ev(2);
		st(33'h100);
		idle;
		st(33'h0);
		ctl(32'h0);
		ev(1);
		idle;
		st(33'h0);
		// General timer on each trigger, random length
		wr(prt_pkg::ADDR_GPT, $urandom_range(3, 1));
		for (int i = 1; i < 4; i++) begin
			ctl((32'(i) << 9) | 32'(i == 3));
			ev(i == 3 ? 1 : i + 2);
			idle;
			// Chained start leaves a one-cycle idle gap; poll again
			if (i == 3) idle;
			st(i == 3 ? 33'h7 : 33'h4);
			`CHK("gpt_flag", 1'b1, fl[2])
			clr;
		end
		ctl(32'h0);
		cmd(32'h10);
		st(33'h800);
		idle;
		st(33'h4);
		clr;
		// Frozen while the crystal is stopped
		osc_ok <= 1'b0;
		cmd(32'h10);
		repeat (1000) @(posedge pclk);
		st(33'h800);
		osc_ok <= 1'b1;
		idle;
		st(33'h4);
		clr;
		// Peer field start of no-response timer
		ctl(32'h81);
		ev(2);
		st(33'h300);
		cmd(32'h1);
		ctl(32'h84);
		ev(2);
		st(33'h0);
		// Wake timer refused in wake mode
		ctl(32'h6);
		wr(prt_pkg::ADDR_WUT, 32'h2);
		cmd(32'h20);
		st(33'h0);
		ctl(32'h0);
		cmd(32'h20);
		`CHK("rc_osc_on", 1'b1, rc_osc_on)
		idle;
		st(33'h8);
		`CHK("wake_flag", 1'b1, fl[3])
		clr;
		// Low-power target watches only after mask expiry
		// Crystal taken down again: mask timer must run on RC ticks
		osc_ok <= 1'b0;
		ctl(32'h15);
		cmd(32'h2);
		`CHK("watch_rx", 1'b0, watch_rx)
		`CHK("rc_osc_on", 1'b1, rc_osc_on)
		idle;
		`CHK("watch_rx", 1'b1, watch_rx)
		tally_and_finish;
	end
endmodule // test_rf_frontend_protocol_timers
`default_nettype wire
